// [rtl/ewt_trip_regs.vh]
// Constants for the event trippoint wait unit.
// Assumes a 125 MHz REF_CLK and a 32-bit AXI4-Lite master.
`ifndef EWT_TRIP_REGS_VH
`define EWT_TRIP_REGS_VH
// Register byte offsets
`define EWT_OFS_PERIOD 8'h00
`define EWT_OFS_TMO 8'h04
`define EWT_OFS_STAT 8'h08
`define EWT_OFS_MASK 8'h0C
`define EWT_OFS_STATE 8'h10
// Reset values
`define EWT_PERIOD_RST 16'h03E8
`define EWT_TMO_RST 16'h0000
`define EWT_MASK_RST 3'h0
// Status and mask bit positions
`define EWT_ST_TRIP 0
`define EWT_ST_TMO 1
`define EWT_ST_REJ 2
// State register fields
`define EWT_SR_STALL 0
`define EWT_SR_OP_LO 4
`define EWT_SR_SC_LO 8
// Trigger opcodes
`define EWT_OP_DONE 4'h0
`define EWT_OP_MDIST 4'h1
`define EWT_OP_INCR 4'h2
`define EWT_OP_ABS 4'h3
`define EWT_OP_FWD 4'h4
`define EWT_OP_REV 4'h5
`define EWT_OP_INPOS 4'h6
`define EWT_OP_INPUT 4'h7
`define EWT_OP_SLEW 4'h8
`define EWT_OP_TREF 4'h9
`define EWT_OP_PATH 4'hA
`define EWT_OP_DELAY 4'hB
// Stop code after an in-position timeout
`define EWT_SC_TMO 8'h63
// Timing
`define EWT_CLK_NS 8
`define EWT_MS_NS 1000000
`define EWT_TM_UNIT_NS 976
// AXI responses
`define EWT_RESP_OK 2'h0
`define EWT_RESP_ERR 2'h2
`endif

// [rtl/ewt_trip_unit.v]
// Event trippoint wait unit: stalls the program sequencer
// until the decoded trigger's condition is met.
// Assumes profiler inputs share REF_CLK; DIG_IN are pins.
//
// Function
// R1: Trigger decode stalls sequencer until tripped
// R2: Wait until all selected axes done
// R3: Release after relative distance from start
// R4: Release after step since previous step
// R5: Wait until absolute position reached
// R6: Forward crossing, immediate if already past
// R7: Reverse crossing, immediate if already past
// R8: In-position wait, timeout sets code, branches
// R9: Wait for input 1..8 at level
// R10: Wait until axis at slew speed
// R11: Time reference capture, wait, rearm
// R12: Unit selector picks samples or milliseconds
// R13: Millisecond delay stalls for n ms
// R14: Millisecond delays independent of sample period
// R15: Default period gives 976 us samples
// R16: Release after path distance covered
// R17: Reject relative move while motion busy
// R18: Position trippoints evaluated per sample
// R19: Re-evaluate each tick, release first hit
`timescale 1ns/10ps
`include "ewt_trip_regs.vh"
module ewt_trip_unit #(
   parameter MS_CYCLES = `EWT_MS_NS / `EWT_CLK_NS
) (
   // Clock and reset
   input wire REF_CLK,
   input wire RST_N,
   // AXI4-Lite slave
   input wire [7:0] AWADDR,
   input wire AWVALID,
   output reg AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output reg WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   input wire [7:0] ARADDR,
   input wire ARVALID,
   output reg ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY,
   // Sequencer trigger port
   input wire TRIG_VALID,
   input wire [3:0] TRIG_OP,
   input wire [31:0] TRIG_ARG,
   input wire TRIG_UNIT,
   input wire TRIG_AUX,
   output reg SEQ_STALL,
   output reg TRIG_DONE,
   output reg TMO_BRANCH,
   output reg [7:0] STOP_CODE,
   // Relative move request
   input wire MOVE_REQ,
   output reg MOVE_ACCEPT,
   output reg MOVE_REJECT,
   // Profiler and feedback
   input wire [3:0] MOTION_DONE,
   input wire MOVE_START,
   input wire AT_SLEW,
   input wire [31:0] CMD_POS,
   input wire [31:0] ENC_POS,
   input wire [31:0] AUX_POS,
   input wire [31:0] PATH_DIST,
   // Digital input pins
   input wire [7:0] DIG_IN,
   // Servo tick and interrupt
   output reg SERVO_TICK,
   output reg IRQ
);

   localparam ST_IDLE = 1'b0;
   localparam ST_WAIT = 1'b1;
   localparam [31:0] TM_UNIT_FULL = `EWT_TM_UNIT_NS / `EWT_CLK_NS;
   localparam [31:0] MS_FULL = MS_CYCLES;
   localparam [23:0] TM_UNIT_CYC = TM_UNIT_FULL[23:0];
   localparam [23:0] MS_CYC = MS_FULL[23:0];

   // Input synchroniser, first stage read only by second
   reg [7:0] din_s1_q;
   reg [7:0] din_s2_q;
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         din_s1_q <= 8'h00;
         din_s2_q <= 8'h00;
      end else begin
         din_s1_q <= DIG_IN;
         din_s2_q <= din_s1_q;
      end
   end

   // Registers
   reg [15:0] period_q;
   reg [15:0] tmo_q;
   reg [2:0] stat_q;
   reg [2:0] mask_q;

   // Sample and millisecond time bases
   reg [23:0] smp_div_q;
   reg [23:0] ms_div_q;
   reg smp_tick_q;
   reg ms_tick_q;
   reg [31:0] smp_cnt_q;
   reg [31:0] ms_cnt_q;
   wire [15:0] period_eff = (period_q == 16'h0000) ? 16'h0001 : period_q;
   wire [39:0] smp_prod = period_eff * TM_UNIT_CYC;
   wire [23:0] smp_len = smp_prod[23:0];
   // R15 sample period from register
   // R14 ms base fixed to REF_CLK, not the period
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         smp_div_q <= 24'h000000;
         ms_div_q <= 24'h000000;
         smp_tick_q <= 1'b0;
         ms_tick_q <= 1'b0;
         smp_cnt_q <= 32'h00000000;
         ms_cnt_q <= 32'h00000000;
      end else begin
         smp_tick_q <= 1'b0;
         ms_tick_q <= 1'b0;
         if (smp_div_q >= smp_len - 24'h000001) begin
            smp_div_q <= 24'h000000;
            smp_tick_q <= 1'b1;
            smp_cnt_q <= smp_cnt_q + 32'h00000001;
         end else begin
            smp_div_q <= smp_div_q + 24'h000001;
         end
         if (ms_div_q >= MS_CYC - 24'h000001) begin
            ms_div_q <= 24'h000000;
            ms_tick_q <= 1'b1;
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
         end else begin
            ms_div_q <= ms_div_q + 24'h000001;
         end
      end
   end

   // Trigger state
   reg state_q;
   reg [3:0] op_q;
   reg [31:0] arg_q;
   reg [31:0] tgt_q;
   reg unit_q;
   reg aux_q;
   reg dir_q;
   reg [31:0] dly_q;
   reg [31:0] tmo_cnt_q;
   reg [31:0] start_q;
   reg [31:0] step_q;
   reg [31:0] path_q;
   reg [31:0] ref_smp_q;
   reg [31:0] ref_ms_q;

   wire [31:0] arg_mag = TRIG_ARG[31] ? (32'h00000000 - TRIG_ARG) : TRIG_ARG;
   wire [31:0] trig_pos = TRIG_AUX ? AUX_POS : CMD_POS;
   wire [31:0] pos_sel = aux_q ? AUX_POS : CMD_POS;
   wire unit_tick = unit_q ? smp_tick_q : ms_tick_q;
   wire timed = (op_q == `EWT_OP_TREF) || (op_q == `EWT_OP_DELAY);
   // R18 position checks only on sample ticks
   wire eval = timed ? unit_tick : smp_tick_q;
   wire [31:0] now_t = unit_q ? smp_cnt_q : ms_cnt_q;
   wire [31:0] ref_t = unit_q ? ref_smp_q : ref_ms_q;
   wire [31:0] elapsed = now_t - ref_t;
   wire [31:0] dly_nx = dly_q + 32'h00000001;
   // Index from the magnitude; the sign only selects the level
   wire [2:0] in_idx = tgt_q[2:0] - 3'h1;
   wire accept = (state_q == ST_IDLE) && TRIG_VALID;
   wire tref_now = (TRIG_OP == `EWT_OP_TREF) && (TRIG_ARG == 32'h00000000);

   function reach;
      input [31:0] p;
      input [31:0] t;
      input d;
      begin
         reach = d ? ($signed(p) >= $signed(t)) : ($signed(p) <= $signed(t));
      end
   endfunction

   reg hit;
   always @* begin
      hit = 1'b0;
      case (op_q)
         // R2 all selected axes done
         `EWT_OP_DONE: hit = &(MOTION_DONE | ~arg_q[3:0]);
         // R3 distance from move start
         `EWT_OP_MDIST: hit = reach(CMD_POS, tgt_q, dir_q);
         // R4 distance from previous step
         `EWT_OP_INCR: hit = reach(CMD_POS, tgt_q, dir_q);
         // R5 absolute position reached
         `EWT_OP_ABS: hit = reach(pos_sel, tgt_q, dir_q);
         // R6 forward crossing
         `EWT_OP_FWD: hit = $signed(pos_sel) >= $signed(tgt_q);
         // R7 reverse crossing
         `EWT_OP_REV: hit = $signed(pos_sel) <= $signed(tgt_q);
         // R8 profile done and encoder at target
         `EWT_OP_INPOS: hit = MOTION_DONE[0] && reach(ENC_POS, tgt_q, dir_q);
         // R9 input level, sign gives level
         `EWT_OP_INPUT: hit = din_s2_q[in_idx] == ~arg_q[31];
         // R10 slew speed reached
         `EWT_OP_SLEW: hit = AT_SLEW;
         // R11 units after reference
         `EWT_OP_TREF: hit = elapsed >= tgt_q;
         // R16 path distance covered
         `EWT_OP_PATH: hit = PATH_DIST >= tgt_q;
         // R13 delay count reached
         `EWT_OP_DELAY: hit = dly_nx >= tgt_q;
         default: hit = 1'b1;
      endcase
   end

   wire tmo_hit = (op_q == `EWT_OP_INPOS) && (tmo_q != 16'h0000) && ms_tick_q &&
      (tmo_cnt_q + 32'h00000001 >= {16'h0000, tmo_q});
   // R19 release on first tick that holds
   wire release_now = (state_q == ST_WAIT) && eval && hit;
   wire tmo_now = (state_q == ST_WAIT) && !(eval && hit) && tmo_hit;
   wire move_busy = !MOTION_DONE[0];

   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         op_q <= `EWT_OP_DONE;
         arg_q <= 32'h00000000;
         tgt_q <= 32'h00000000;
         unit_q <= 1'b0;
         aux_q <= 1'b0;
         dir_q <= 1'b0;
         dly_q <= 32'h00000000;
         tmo_cnt_q <= 32'h00000000;
         start_q <= 32'h00000000;
         step_q <= 32'h00000000;
         path_q <= 32'h00000000;
         ref_smp_q <= 32'h00000000;
         ref_ms_q <= 32'h00000000;
         SEQ_STALL <= 1'b0;
         TRIG_DONE <= 1'b0;
         TMO_BRANCH <= 1'b0;
         STOP_CODE <= 8'h00;
         MOVE_ACCEPT <= 1'b0;
         MOVE_REJECT <= 1'b0;
      end else begin
         TRIG_DONE <= 1'b0;
         TMO_BRANCH <= 1'b0;
         MOVE_ACCEPT <= 1'b0;
         MOVE_REJECT <= 1'b0;
         // R17 relative move refused while moving
         if (MOVE_REQ) begin
            MOVE_ACCEPT <= !move_busy;
            MOVE_REJECT <= move_busy;
         end
         if (MOVE_START) begin
            start_q <= CMD_POS;
            step_q <= CMD_POS;
            path_q <= PATH_DIST;
         end
         if (accept && tref_now) begin
            // R11 zero argument captures reference
            ref_smp_q <= smp_cnt_q;
            ref_ms_q <= ms_cnt_q;
            TRIG_DONE <= 1'b1;
         end else if (accept) begin
            // R1 stall until tripped
            state_q <= ST_WAIT;
            SEQ_STALL <= 1'b1;
            op_q <= TRIG_OP;
            arg_q <= TRIG_ARG;
            // R12 selector 1 is samples
            unit_q <= TRIG_UNIT;
            aux_q <= TRIG_AUX;
            dly_q <= 32'h00000000;
            tmo_cnt_q <= 32'h00000000;
            dir_q <= !TRIG_ARG[31];
            case (TRIG_OP)
               `EWT_OP_MDIST: tgt_q <= start_q + TRIG_ARG;
               `EWT_OP_INCR: tgt_q <= step_q + TRIG_ARG;
               `EWT_OP_PATH: tgt_q <= path_q + arg_mag;
               `EWT_OP_TREF: tgt_q <= arg_mag;
               `EWT_OP_DELAY: tgt_q <= arg_mag;
               `EWT_OP_INPUT: tgt_q <= arg_mag;
               default: tgt_q <= TRIG_ARG;
            endcase
            if (TRIG_OP == `EWT_OP_ABS)
               dir_q <= $signed(TRIG_ARG) >= $signed(trig_pos);
            if (TRIG_OP == `EWT_OP_INPOS)
               dir_q <= $signed(TRIG_ARG) >= $signed(ENC_POS);
         end
         if (state_q == ST_WAIT) begin
            if (unit_tick)
               dly_q <= dly_nx;
            if (ms_tick_q)
               tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
         end
         if (release_now) begin
            state_q <= ST_IDLE;
            SEQ_STALL <= 1'b0;
            TRIG_DONE <= 1'b1;
            // R4 step reference follows each MDIST or INCR release
            if ((op_q == `EWT_OP_MDIST) || (op_q == `EWT_OP_INCR))
               step_q <= tgt_q;
            // R16 path reference follows each PATH release
            if (op_q == `EWT_OP_PATH)
               path_q <= tgt_q;
            // R11 negative argument rearms reference
            if ((op_q == `EWT_OP_TREF) && arg_q[31]) begin
               if (unit_q)
                  ref_smp_q <= smp_cnt_q;
               else
                  ref_ms_q <= ms_cnt_q;
            end
         end else if (tmo_now) begin
            // R8 timeout clears, code 99, branch
            state_q <= ST_IDLE;
            SEQ_STALL <= 1'b0;
            STOP_CODE <= `EWT_SC_TMO;
            TMO_BRANCH <= 1'b1;
         end
      end
   end

   // AXI4-Lite write path
   wire wr_go = AWVALID && WVALID && AWREADY && WREADY;
   wire [31:0] wmask = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
   wire [31:0] wr_per = ({16'h0000, period_q} & ~wmask) | (WDATA & wmask);
   wire [31:0] wr_tmo = ({16'h0000, tmo_q} & ~wmask) | (WDATA & wmask);
   wire [2:0] ev = {MOVE_REQ && move_busy, tmo_now, release_now || (accept && tref_now)};
   reg [2:0] w1c;
   reg wr_ok;
   always @* begin
      w1c = 3'h0;
      wr_ok = 1'b0;
      if (AWADDR == `EWT_OFS_PERIOD) begin
         wr_ok = 1'b1;
      end else if (AWADDR == `EWT_OFS_TMO) begin
         wr_ok = 1'b1;
      end else if (AWADDR == `EWT_OFS_STAT) begin
         wr_ok = 1'b1;
         if (wr_go && WSTRB[0])
            w1c = WDATA[2:0];
      end else if (AWADDR == `EWT_OFS_MASK) begin
         wr_ok = 1'b1;
      end else if (AWADDR == `EWT_OFS_STATE) begin
         wr_ok = 1'b1;
      end
   end

   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= `EWT_RESP_OK;
         period_q <= `EWT_PERIOD_RST;
         tmo_q <= `EWT_TMO_RST;
         mask_q <= `EWT_MASK_RST;
         stat_q <= 3'h0;
         IRQ <= 1'b0;
      end else begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         if (AWVALID && WVALID && !AWREADY && !BVALID) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
         if (wr_go) begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `EWT_RESP_OK : `EWT_RESP_ERR;
            if (AWADDR == `EWT_OFS_PERIOD)
               period_q <= wr_per[15:0];
            if (AWADDR == `EWT_OFS_TMO)
               tmo_q <= wr_tmo[15:0];
            if ((AWADDR == `EWT_OFS_MASK) && WSTRB[0])
               mask_q <= WDATA[2:0];
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
         // Set wins over a same-cycle clear
         stat_q <= (stat_q & ~w1c) | ev;
         IRQ <= |(((stat_q & ~w1c) | ev) & mask_q);
      end
   end

   // AXI4-Lite read path
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      if (ARADDR == `EWT_OFS_PERIOD) begin
         rd_val = {16'h0000, period_q};
      end else if (ARADDR == `EWT_OFS_TMO) begin
         rd_val = {16'h0000, tmo_q};
      end else if (ARADDR == `EWT_OFS_STAT) begin
         rd_val = {29'h00000000, stat_q};
      end else if (ARADDR == `EWT_OFS_MASK) begin
         rd_val = {29'h00000000, mask_q};
      end else if (ARADDR == `EWT_OFS_STATE) begin
         rd_val[`EWT_SR_STALL] = SEQ_STALL;
         rd_val[`EWT_SR_OP_LO+3:`EWT_SR_OP_LO] = op_q;
         rd_val[`EWT_SR_SC_LO+7:`EWT_SR_SC_LO] = STOP_CODE;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= `EWT_RESP_OK;
         SERVO_TICK <= 1'b0;
      end else begin
         SERVO_TICK <= smp_tick_q;
         ARREADY <= 1'b0;
         if (ARVALID && !ARREADY && !RVALID)
            ARREADY <= 1'b1;
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA <= rd_val;
            RRESP <= rd_ok ? `EWT_RESP_OK : `EWT_RESP_ERR;
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

endmodule // ewt_trip_unit

// [sim/ewt_prof_model.sv]
// Profiler stand-in: a move runs one count per clock.
// Assumes start pulses come only from accepted moves.
`timescale 1ns/10ps
module ewt_prof_model #(
   parameter DIST = 2000
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   output reg [3:0] done,
   output reg mstart,
   output reg slew,
   output reg [31:0] cmd,
   output reg [31:0] enc,
   output wire [31:0] aux,
   output reg [31:0] path
);
   reg [31:0] left_q;
   // Aux input runs backwards to exercise reverse crossings
   assign aux = 32'h0 - cmd;
   always @(posedge clk) begin
      mstart <= start;
      if (!rst_n) begin
         left_q <= 32'h0;
         cmd <= 32'h0;
         path <= 32'h0;
      end else if (start) begin
         left_q <= DIST;
      end else if (left_q != 32'h0) begin
         left_q <= left_q - 32'h1;
         cmd <= cmd + 32'h1;
         path <= path + 32'h1;
      end
      enc <= cmd;
      slew <= left_q != 32'h0 && left_q < DIST - 32'h10;
      done <= {3'h7, left_q == 32'h0};
   end
endmodule // ewt_prof_model

// [sim/ewt_trip_mon_monitor.sv]
// Checker for the trippoint unit, bound to its top.
// Assumes the master keeps one bus request at a time.
`timescale 1ns/10ps
`include "ewt_trip_regs.vh"
module ewt_trip_mon (
   // Clock and reset
   input wire REF_CLK,
   input wire RST_N,
   // Register bus
   input wire AWREADY,
   input wire WREADY,
   input wire BVALID,
   input wire BREADY,
   input wire ARREADY,
   input wire [7:0] ARADDR,
   input wire RVALID,
   input wire [1:0] RRESP,
   // Trigger port
   input wire TRIG_VALID,
   input wire [3:0] TRIG_OP,
   input wire SEQ_STALL,
   input wire TRIG_DONE,
   input wire TMO_BRANCH,
   input wire [7:0] STOP_CODE,
   // Moves and tick
   input wire MOVE_REQ,
   input wire MOVE_ACCEPT,
   input wire MOVE_REJECT,
   input wire [3:0] MOTION_DONE,
   input wire SERVO_TICK
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence wr_take;
      AWREADY && WREADY;
   endsequence
   sequence rd_bad;
      ARREADY && ARADDR > 8'h10 ##1 RVALID;
   endsequence
   stall_take_a: assert property (TRIG_VALID && !SEQ_STALL && TRIG_OP != `EWT_OP_TREF |=> SEQ_STALL)
      else $error("trigger did not stall");
   release_pulse_a: assert property ($fell(SEQ_STALL) |-> TRIG_DONE || TMO_BRANCH)
      else $error("release without pulse");
   done_free_a: assert property (TRIG_DONE |-> !SEQ_STALL)
      else $error("done while stalled");
   tmo_code_a: assert property (TMO_BRANCH |-> STOP_CODE == `EWT_SC_TMO)
      else $error("timeout stop code wrong");
   move_rej_a: assert property (MOVE_REQ && !MOTION_DONE[0] |=> MOVE_REJECT && !MOVE_ACCEPT)
      else $error("busy move not refused");
   move_acc_a: assert property (MOVE_REQ && MOTION_DONE[0] |=> MOVE_ACCEPT && !MOVE_REJECT)
      else $error("idle move not taken");
   tick_gap_a: assert property (SERVO_TICK |=> !SERVO_TICK [*8])
      else $error("sample ticks too close");
   wr_resp_a: assert property (wr_take |=> BVALID)
      else $error("write response late");
   b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   rd_err_a: assert property (rd_bad |-> RRESP == `EWT_RESP_ERR)
      else $error("unmapped read not refused");
endmodule // ewt_trip_mon
bind ewt_trip_unit ewt_trip_mon u_ewt_trip_mon (.*);

// [sim/ewt_trip_unit_tb_top.sv]
// Bench for the trippoint unit with a profiler model.
// Assumes ms ticks shortened to 10 clocks, 122-clock samples.
`timescale 1ns/10ps
`include "ewt_trip_regs.vh"
module ewt_trip_unit_tb_top;
   reg REF_CLK = 1'h0, RST_N = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
   reg ARVALID = 1'h0, RREADY = 1'h0, TRIG_VALID = 1'h0, TRIG_UNIT = 1'h0, TRIG_AUX = 1'h0;
   reg MOVE_REQ = 1'h0, lvl;
   reg [7:0] AWADDR = 8'h0, ARADDR = 8'h0, DIG_IN = 8'h0;
   reg [31:0] WDATA = 32'h0, TRIG_ARG = 32'h0, st, p0;
   reg [3:0] TRIG_OP = 4'h0;
   reg [15:0] lf = 16'h14;
   wire [3:0] WSTRB = 4'hF;
   wire AWREADY, WREADY, BVALID, ARREADY, RVALID, SEQ_STALL, TRIG_DONE, TMO_BRANCH;
   wire MOVE_ACCEPT, MOVE_REJECT, MOVE_START, AT_SLEW, SERVO_TICK, IRQ;
   wire [1:0] BRESP, RRESP;
   wire [31:0] RDATA, CMD_POS, ENC_POS, AUX_POS, PATH_DIST;
   wire [7:0] STOP_CODE;
   wire [3:0] MOTION_DONE;
   integer fails = 0, cmp_count = 0, cyc = 0, t0, dur, i, n;
   reg [33:0] rq[$];
   reg [3:0] eq[$];
   ewt_trip_unit #(.MS_CYCLES(10)) u_ewt_trip_unit (.*);
   ewt_prof_model u_ewt_prof_model (.clk(REF_CLK), .rst_n(RST_N), .start(MOVE_ACCEPT), .done(MOTION_DONE),
      .mstart(MOVE_START), .slew(AT_SLEW), .cmd(CMD_POS), .enc(ENC_POS), .aux(AUX_POS), .path(PATH_DIST));
   function [15:0] lfsr(input [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task bad(input [33:0] g, input [33:0] e);
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task chk_bus(input [33:0] g, input [33:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) bad(g, e);
   endtask
   task chk_ev(input [3:0] g, input [3:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) bad(g, e);
   endtask
   task chk_rng(input [31:0] g, input [31:0] lo, input [31:0] hi);
      cmp_count = cmp_count + 1;
      if ((g >= lo && g <= hi) !== 1'h1) bad(g, lo);
   endtask
   task give_verdict;
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial forever #4 REF_CLK = ~REF_CLK;
   // Watcher: every result retires the oldest note
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (RVALID && RREADY) chk_bus({RRESP, RDATA}, rq.pop_front());
      if (BVALID && BREADY) chk_bus({BRESP, 32'h0}, rq.pop_front());
      if (TRIG_DONE || TMO_BRANCH || MOVE_ACCEPT || MOVE_REJECT)
         chk_ev({TMO_BRANCH, TRIG_DONE, MOVE_REJECT, MOVE_ACCEPT}, eq.pop_front());
      if (cyc == 60000) begin
         fails = fails + 1;
         give_verdict;
      end
   end
   task wr(input [7:0] a, input [31:0] d, input [1:0] r);
      rq.push_back({r, 32'h0});
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      @(posedge REF_CLK);
      while (AWREADY !== 1'h1) @(posedge REF_CLK);
      AWVALID <= 1'h0;
      WVALID <= 1'h0;
      while (BVALID !== 1'h1) @(posedge REF_CLK);
      BREADY <= 1'h0;
      @(posedge REF_CLK);
   endtask
   task rd(input [7:0] a, input [33:0] e);
      rq.push_back(e);
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      @(posedge REF_CLK);
      while (ARREADY !== 1'h1) @(posedge REF_CLK);
      ARVALID <= 1'h0;
      while (RVALID !== 1'h1) @(posedge REF_CLK);
      RREADY <= 1'h0;
      @(posedge REF_CLK);
   endtask
   task trig(input [3:0] op, input [31:0] a, input u, input x, input [3:0] ev);
      eq.push_back(ev);
      @(posedge REF_CLK);
      TRIG_OP <= op;
      TRIG_ARG <= a;
      TRIG_UNIT <= u;
      TRIG_AUX <= x;
      TRIG_VALID <= 1'h1;
      @(posedge REF_CLK);
      TRIG_VALID <= 1'h0;
      t0 = cyc;
      while ((TRIG_DONE || TMO_BRANCH) !== 1'h1) @(posedge REF_CLK);
      dur = cyc - t0;
      p0 = CMD_POS;
   endtask
   // Overshoot allowed: one sample of travel plus pipeline
   task pos(input [3:0] op, input [31:0] a, input x, input [31:0] lo);
      trig(op, a, 1'h0, x, 4'h4);
      chk_rng(p0 - st, lo, lo + 130);
   endtask
   task mreq(input [3:0] ev);
      eq.push_back(ev);
      @(posedge REF_CLK);
      MOVE_REQ <= 1'h1;
      @(posedge REF_CLK);
      MOVE_REQ <= 1'h0;
      repeat (3) @(posedge REF_CLK);
   endtask
   initial begin
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1'h1;
      @(posedge REF_CLK);
      rd(`EWT_OFS_PERIOD, 34'h3E8);
      rd(8'h14, 34'h200000000);
      wr(`EWT_OFS_PERIOD, 32'h1, 2'h0);
      wr(`EWT_OFS_TMO, 32'h10, 2'h0);
      wr(`EWT_OFS_MASK, 32'h7, 2'h0);
      wr(8'h40, 32'h0, 2'h2);
      repeat (2) @(posedge SERVO_TICK);
      for (i = 0; i < 4; i = i + 1) begin
         lf = lfsr(lf);
         n = lf[1:0] + 1;
         trig(`EWT_OP_DELAY, n, i[0], 1'h0, 4'h4);
         chk_rng(dur, (n - 1) * (i[0] ? 122 : 10), n * (i[0] ? 122 : 10) + 3);
      end
      trig(`EWT_OP_TREF, 32'h0, 1'h0, 1'h0, 4'h4);
      chk_rng(dur, 1, 2);
      trig(`EWT_OP_TREF, 32'hFFFFFFFE, 1'h0, 1'h0, 4'h4);
      chk_rng(dur, 6, 24);
      trig(`EWT_OP_TREF, 32'h3, 1'h0, 1'h0, 4'h4);
      chk_rng(dur, 24, 34);
      st = CMD_POS;
      mreq(4'h1);
      pos(`EWT_OP_SLEW, 32'h0, 1'h0, 32'h10);
      mreq(4'h2);
      chk_rng(IRQ, 1, 1);
      pos(`EWT_OP_MDIST, 32'h12C, 1'h0, 32'h12C);
      pos(`EWT_OP_INCR, 32'h12C, 1'h0, 32'h258);
      pos(`EWT_OP_ABS, st + 32'h3E8, 1'h0, 32'h3E8);
      pos(`EWT_OP_PATH, 32'h514, 1'h0, 32'h514);
      pos(`EWT_OP_REV, 32'h0 - st - 32'h6A4, 1'h1, 32'h6A4);
      trig(`EWT_OP_FWD, st, 1'h0, 1'h0, 4'h4);
      chk_rng(dur, 1, 126);
      trig(`EWT_OP_DONE, 32'h1, 1'h0, 1'h0, 4'h4);
      chk_rng(p0 - st, 32'h7D0, 32'h7D0);
      trig(`EWT_OP_INPOS, st + 32'h7D0, 1'h0, 1'h0, 4'h4);
      trig(`EWT_OP_INPOS, st + 32'h1388, 1'h0, 1'h0, 4'h8);
      chk_rng(dur, 148, 164);
      chk_rng(STOP_CODE, `EWT_SC_TMO, `EWT_SC_TMO);
      wr(`EWT_OFS_MASK, 32'h0, 2'h0);
      wr(`EWT_OFS_STAT, 32'h7, 2'h0);
      for (i = 0; i < 8; i = i + 1) begin
         lf = lfsr(lf);
         lvl = lf[0];
         DIG_IN <= (lf[15:8] & ~(8'h1 << i)) | ({7'h0, ~lvl} << i);
         fork
            trig(`EWT_OP_INPUT, lvl ? i + 1 : 32'h0 - i - 1, 1'h0, 1'h0, 4'h4);
            begin
               repeat (300) @(posedge REF_CLK);
               DIG_IN[i] <= lvl;
            end
         join
         chk_rng(dur, 296, 440);
      end
      chk_rng(IRQ, 0, 0);
      wr(`EWT_OFS_MASK, 32'h1, 2'h0);
      @(posedge REF_CLK);
      chk_rng(IRQ, 1, 1);
      wr(`EWT_OFS_STAT, 32'h1, 2'h0);
      @(posedge REF_CLK);
      chk_rng(IRQ, 0, 0);
      rd(`EWT_OFS_STAT, 34'h0);
      chk_rng(eq.size(), 0, 0);
      give_verdict;
   end
endmodule // ewt_trip_unit_tb_top
